// ---- dtap_host_port.v ----
// How it works
// [RQ1] Host times custom bursts with burst off.
// [RQ2] Single-tone mode outputs one group tone.
// [RQ3] Low strobe pin at select: strobe timing.
// [RQ4] High strobe pin at select: separate strobes.
// [RQ5] Address latched per detected bus type.
// [RQ6] Status updates without host strobe activity.
// [RQ7] Host gives a real select falling edge.
// [RQ8] One register access per select assertion.
// [RQ9] Receive digit holds last valid code.
// [RQ10] Transmit digit write picks tone pair.
// [RQ11] Bank bit steers one write to B.
// [RQ12] Status register reports transceiver state.
// [RQ13] Host initialises both control words first.
// [RQ14] Interrupt on valid digit or burst ready.
// [RQ15] Pin may copy call-progress square wave.
// [RQ16] Alert pin only pulls low or floats.
// [RQ17] Write: select 0 transmit, 1 control.
// [RQ18] Read: select 0 receive, 1 status.
// [RQ19] Too-short tone leaves receive digit alone.
// [RQ20] Valid tone latches its code.
// [RQ21] Code kept until next valid tone.
// [RQ22] Short dropout neither ends tone nor changes.
// [RQ23] Control A b2 enables interrupt pin.
// [RQ24] Control A b1 selects call-progress mode.
// [RQ25] Control B b0 high disables burst mode.
// [RQ26] Control B b2 selects single tone.
// [RQ27] Bus type holds for the whole assertion.
`include "dtap_regs.vh"
`default_nettype none
module dtap_host_port #(
    parameter BURST_CYC = `DTAP_BURST_US * `DTAP_CLK_MHZ,
    parameter GTP_CYC   = `DTAP_GTP_US * `DTAP_CLK_MHZ,
    parameter GTA_CYC   = `DTAP_GTA_US * `DTAP_CLK_MHZ
) (
    input  wire       core_clk,
    input  wire       rst_b,
    input  wire       cs_b,
    input  wire       strobe_or_read_pin,
    input  wire       rw_or_write_pin,
    input  wire       register_select_line,
    input  wire [3:0] data_in,
    output reg  [3:0] data_out_ff,
    output reg        data_oe_b_ff,
    output reg        alert_tone_pin_out_ff,
    output reg        alert_tone_pin_oe_b_ff,
    input  wire       tone_present,
    input  wire [3:0] tone_code,
    input  wire       cp_square,
    output reg  [3:0] tx_code_ff,
    output reg        tone_output_enable_ff,
    output reg        single_tone_ff,
    output reg        tone_group_ff,
    output reg        rx_power_down_ff,
    output reg        tone_detect_mode_bit_ff
);
    localparam ST_IDLE  = 2'd0;
    localparam ST_TONE  = 2'd1;
    localparam ST_PAUSE = 2'd2;

    // Pin inputs cross into the core clock through two flops.
    wire [8:0] pins_s;
    dtap_sync2 #(
        .W (9)
    ) u_sync (
        .core_clk    (core_clk),
        .rst_b       (rst_b),
        .async_in    ({cp_square, data_in, register_select_line,
                       rw_or_write_pin, strobe_or_read_pin, cs_b}),
        .sync_out_ff (pins_s)
    );
    wire       cs_s  = pins_s[0];
    wire       sor_s = pins_s[1];
    wire       rw_s  = pins_s[2];
    wire       rs_s  = pins_s[3];
    wire [3:0] d_s   = pins_s[7:4];
    wire       cp_s  = pins_s[8];

    reg        cs_prv_ff;
    reg        split_ff;
    reg        rs_ff;
    reg        act_ff;
    reg        done_ff;
    reg        rd_ff;
    reg [3:0]  wdat_ff;
    reg [3:0]  cra_ff;
    reg [3:0]  crb_ff;
    reg        bank_pointer_bit_ff;
    reg [3:0]  rx_digit_ff;
    reg [3:0]  state_ff;
    reg [1:0]  burst_st_ff;
    reg [31:0] burst_cnt_ff;
    reg [31:0] guard_cnt_ff;

    wire cs_fall = cs_prv_ff & ~cs_s;

    // Strobe decode under the bus style caught at the last select edge.
    wire is_rd = split_ff ? ~sor_s : rw_s;
    // The write qualifier sits on the same pin in both bus styles.
    wire is_wr = ~rw_s;
    wire stb   = split_ff ? (~sor_s | ~rw_s) : sor_s;
    wire start = ~cs_s & ~cs_fall & ~act_ff & ~done_ff & stb;
    wire fin   = act_ff & (~stb | cs_s);
    wire wr_go = fin & ~rd_ff;
    wire rd_go = fin & rd_ff;
    wire wr_tx = wr_go & (rs_ff == `DTAP_RS_DATA);
    wire wr_ct = wr_go & (rs_ff == `DTAP_RS_CTRL);

    wire tone_output_enable     = cra_ff[`DTAP_CRA_TONE_OUTPUT_ENABLE];
    wire cp_mode  = cra_ff[`DTAP_CRA_CPMODE];
    wire irq_en   = cra_ff[`DTAP_CRA_IRQEN];
    wire burst_on = ~crb_ff[`DTAP_CRB_BURST_OFF];
    // Call-progress mode blinds the digit detector as well as power down.
    wire rx_on    = ~crb_ff[`DTAP_CRB_RX_OFF] & ~cp_mode; // RQ24
    wire steer    = state_ff[`DTAP_ST_STEER];

    // Burst and pause last twice as long in call-progress mode.
    wire [31:0] burst_len = cp_mode ? (BURST_CYC * 2) : BURST_CYC;

    // A digit is taken on the last cycle of an unbroken present guard.
    wire rx_valid = ~steer & rx_on & tone_present &
                    (guard_cnt_ff == GTP_CYC - 1);
    wire rx_gone  = steer & ~tone_present &
                    (guard_cnt_ff == GTA_CYC - 1);
    // Ready is flagged only once the pause has run out in full.
    wire tx_ready = (burst_st_ff == ST_PAUSE) &
                    (burst_cnt_ff == 32'h0000_0000);

    // Bus access framing.
    always @(posedge core_clk) begin
        if (!rst_b) begin
            // The synchroniser also resets low, so a low start here keeps
            // reset release from looking like a select falling edge.
            cs_prv_ff <= 1'b0;
            split_ff  <= 1'b0;
            rs_ff     <= 1'b0;
            act_ff    <= 1'b0;
            done_ff   <= 1'b0;
            rd_ff     <= 1'b0;
            wdat_ff   <= 4'h0;
        end else begin
            cs_prv_ff <= cs_s;
            if (cs_fall) begin
                split_ff <= sor_s; // RQ3 RQ4 RQ27
                rs_ff    <= rs_s; // RQ5
                done_ff  <= 1'b0;
            end else if (cs_s) begin
                done_ff <= 1'b0;
            end
            if (start) begin
                act_ff <= 1'b1;
                rd_ff  <= is_rd & ~(is_wr & ~split_ff);
                // Strobe-style buses keep address stable until the strobe.
                if (!split_ff) begin
                    rs_ff <= rs_s; // RQ5
                end
            end
            if (act_ff && stb && !rd_ff) begin
                wdat_ff <= d_s;
            end
            if (fin) begin
                act_ff  <= 1'b0;
                // Done blocks a second strobe until select goes high again.
                done_ff <= ~cs_s; // RQ8
            end
        end
    end

    // Read data drive; the bus floats outside a read strobe.
    // The word is refreshed every cycle, so it already stands when drive starts.
    always @(posedge core_clk) begin
        if (!rst_b) begin
            data_out_ff  <= 4'h0;
            data_oe_b_ff <= 1'b1;
        end else begin
            if (rs_ff == `DTAP_RS_DATA) begin
                data_out_ff <= rx_digit_ff; // RQ18
            end else begin
                data_out_ff <= state_ff; // RQ18 RQ12
            end
            data_oe_b_ff <= ~(act_ff & rd_ff & ~fin);
        end
    end

    // Control words share one address.
    // Every write to A reloads the pointer, and one write to B returns it.
    always @(posedge core_clk) begin
        if (!rst_b) begin
            cra_ff              <= `DTAP_CTRL_RST;
            crb_ff              <= `DTAP_CTRL_RST;
            bank_pointer_bit_ff <= 1'b0;
        end else if (wr_ct) begin // RQ17
            if (bank_pointer_bit_ff) begin
                crb_ff              <= wdat_ff; // RQ11
                bank_pointer_bit_ff <= 1'b0; // RQ11
            end else begin
                cra_ff              <= wdat_ff;
                bank_pointer_bit_ff <= wdat_ff[`DTAP_CRA_BANK]; // RQ11
            end
        end
    end

    // Transmitter and burst timer.
    always @(posedge core_clk) begin
        if (!rst_b) begin
            tx_code_ff   <= `DTAP_DIGIT_RST;
            burst_st_ff  <= ST_IDLE;
            burst_cnt_ff <= 32'h0000_0000;
        end else if (!tone_output_enable) begin
            // Powering the transmitter down clears the digit.
            tx_code_ff   <= `DTAP_DIGIT_RST;
            burst_st_ff  <= ST_IDLE;
            burst_cnt_ff <= 32'h0000_0000;
        end else if (wr_tx) begin // RQ17
            tx_code_ff <= wdat_ff; // RQ10
            if (burst_on) begin
                burst_st_ff  <= ST_TONE; // RQ25
                burst_cnt_ff <= burst_len - 32'h0000_0001;
            end else begin
                burst_st_ff <= ST_IDLE;
            end
        end else begin
            case (burst_st_ff)
                ST_IDLE: begin
                    // Idling at zero keeps a stale count from flagging ready.
                    burst_cnt_ff <= 32'h0000_0000;
                end
                ST_TONE: begin
                    if (burst_cnt_ff == 32'h0000_0000) begin
                        burst_st_ff  <= ST_PAUSE;
                        burst_cnt_ff <= burst_len - 32'h0000_0001;
                    end else begin
                        burst_cnt_ff <= burst_cnt_ff - 32'h0000_0001;
                    end
                end
                ST_PAUSE: begin
                    if (burst_cnt_ff == 32'h0000_0000) begin
                        burst_st_ff <= ST_IDLE;
                    end else begin
                        burst_cnt_ff <= burst_cnt_ff - 32'h0000_0001;
                    end
                end
                default: begin
                    burst_st_ff <= ST_IDLE;
                end
            endcase
        end
    end

    // Tone output steering to the synthesiser.
    always @(posedge core_clk) begin
        if (!rst_b) begin
            tone_output_enable_ff   <= 1'b0;
            single_tone_ff          <= 1'b0;
            tone_group_ff           <= 1'b0;
            rx_power_down_ff        <= 1'b1;
            tone_detect_mode_bit_ff <= 1'b0;
        end else begin
            // Without burst mode the host gates the tone through this bit.
            tone_output_enable_ff   <= tone_output_enable & (~burst_on |
                                       (burst_st_ff == ST_TONE)); // RQ25 RQ1
            single_tone_ff          <= crb_ff[`DTAP_CRB_SINGLE]; // RQ26 RQ2
            tone_group_ff           <= crb_ff[`DTAP_CRB_GROUP]; // RQ2
            rx_power_down_ff        <= crb_ff[`DTAP_CRB_RX_OFF];
            tone_detect_mode_bit_ff <= cp_mode; // RQ24
        end
    end

    // Receive steering: present and absent guard times.
    always @(posedge core_clk) begin
        if (!rst_b) begin
            guard_cnt_ff <= 32'h0000_0000;
            rx_digit_ff  <= `DTAP_DIGIT_RST;
        end else if (!steer) begin
            // The present guard counts unbroken tone only; a gap starts it afresh.
            if (!(rx_on && tone_present) || rx_valid) begin
                guard_cnt_ff <= 32'h0000_0000; // RQ19
            end else begin
                guard_cnt_ff <= guard_cnt_ff + 32'h0000_0001;
            end
            if (rx_valid) begin
                rx_digit_ff <= tone_code; // RQ20 RQ9
            end
        end else begin
            // A dropout shorter than the absent guard restarts the count.
            if (tone_present || rx_gone) begin
                guard_cnt_ff <= 32'h0000_0000; // RQ22 RQ21
            end else begin
                guard_cnt_ff <= guard_cnt_ff + 32'h0000_0001;
            end
        end
    end

    // Transceiver state flags change on hardware events and also on host reads and writes.
    // A read clears its flag at the strobe end; an event landing between the
    // host's sample and that end is lost, so the host should poll once more.
    always @(posedge core_clk) begin
        if (!rst_b) begin
            state_ff <= `DTAP_STATE_RST;
        end else begin
            // Set wins over a read clear arriving in the same cycle.
            if (rx_valid || (tx_ready && burst_on)) begin
                state_ff[`DTAP_ST_IRQ] <= 1'b1; // RQ14 RQ6
            end else if (rd_go && rs_ff == `DTAP_RS_CTRL) begin
                state_ff[`DTAP_ST_IRQ] <= 1'b0;
            end
            if (tx_ready || !tone_output_enable) begin
                state_ff[`DTAP_ST_TX_EMPTY] <= 1'b1; // RQ12
            end else if (wr_tx && burst_on) begin
                state_ff[`DTAP_ST_TX_EMPTY] <= 1'b0;
            end
            if (rx_valid) begin
                state_ff[`DTAP_ST_RX_FULL] <= 1'b1; // RQ12
            end else if (rd_go && rs_ff == `DTAP_RS_DATA) begin
                state_ff[`DTAP_ST_RX_FULL] <= 1'b0;
            end
            if (rx_valid) begin
                state_ff[`DTAP_ST_STEER] <= 1'b1;
            end else if (rx_gone || !rx_on) begin
                state_ff[`DTAP_ST_STEER] <= 1'b0;
            end
        end
    end

    // Shared alert pin: open drain, pulls low or floats.
    always @(posedge core_clk) begin
        if (!rst_b) begin
            alert_tone_pin_out_ff  <= 1'b0;
            alert_tone_pin_oe_b_ff <= 1'b1;
        end else begin
            alert_tone_pin_out_ff <= 1'b0; // RQ16
            if (!irq_en) begin
                alert_tone_pin_oe_b_ff <= 1'b1; // RQ23
            end else if (cp_mode) begin
                // The synchronised comparator steers the pull-down directly.
                alert_tone_pin_oe_b_ff <= cp_s; // RQ15
            end else begin
                alert_tone_pin_oe_b_ff <= ~state_ff[`DTAP_ST_IRQ]; // RQ14 RQ23
            end
        end
    end
endmodule
`default_nettype wire

// ---- dtap_regs.vh ----
`ifndef DTAP_REGS_VH
`define DTAP_REGS_VH

// Register select decode.
`define DTAP_RS_DATA        1'b0
`define DTAP_RS_CTRL        1'b1

// Control word A fields.
`define DTAP_CRA_TONE_OUTPUT_ENABLE       0
`define DTAP_CRA_CPMODE     1
`define DTAP_CRA_IRQEN      2
`define DTAP_CRA_BANK       3

// Control word B fields.
`define DTAP_CRB_BURST_OFF  0
`define DTAP_CRB_RX_OFF     1
`define DTAP_CRB_SINGLE     2
`define DTAP_CRB_GROUP      3

// Transceiver state fields.
`define DTAP_ST_IRQ         0
`define DTAP_ST_TX_EMPTY    1
`define DTAP_ST_RX_FULL     2
`define DTAP_ST_STEER       3

// Reset values.
`define DTAP_CTRL_RST       4'h0
`define DTAP_DIGIT_RST      4'h0
`define DTAP_STATE_RST      4'h2

// Timing: clock in MHz, durations in microseconds.
`define DTAP_CLK_MHZ        200
`define DTAP_BURST_US       51000
`define DTAP_GTP_US         40
`define DTAP_GTA_US         40

`endif

// ---- dtap_sync2.v ----
`default_nettype none
module dtap_sync2 #(
    parameter W = 1
) (
    input  wire         core_clk,
    input  wire         rst_b,
    input  wire [W-1:0] async_in,
    output reg  [W-1:0] sync_out_ff
);
    // The first stage feeds only the second stage.
    reg [W-1:0] meta_ff;

    always @(posedge core_clk) begin
        if (!rst_b) begin
            meta_ff     <= {W{1'b0}};
            sync_out_ff <= {W{1'b0}};
        end else begin
            meta_ff     <= async_in;
            sync_out_ff <= meta_ff;
        end
    end
endmodule
`default_nettype wire

// ---- dtap_host_port_asserts.sv ----
`default_nettype none
module dtap_host_port_asserts (
    input wire logic       core_clk,
    input wire logic       rst_b,
    input wire logic       cs_b,
    input wire logic       rw_or_write_pin,
    input wire logic       data_oe_b_ff,
    input wire logic       alert_tone_pin_out_ff,
    input wire logic       alert_tone_pin_oe_b_ff,
    input wire logic [3:0] tx_code_ff,
    input wire logic       tone_output_enable_ff,
    input wire logic       single_tone_ff,
    input wire logic       tone_group_ff,
    input wire logic       rx_power_down_ff,
    input wire logic       tone_detect_mode_bit_ff
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [3:0] idle_ff;
    // Settings may only move shortly after a select or a reset; saturate to avoid wrapping.
    always_ff @(posedge core_clk) begin
        if (!rst_b || !cs_b) begin
            idle_ff <= 4'h0;
        end else if (idle_ff != 4'hf) begin
            idle_ff <= idle_ff + 4'h1;
        end
    end
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rst_b);
    a_alert_open_drain: assert property (alert_tone_pin_out_ff == 1'b0)
        else $error("alert pin driven high");
    a_read_drive_cause: assert property ($fell(data_oe_b_ff) |->
        !$past(cs_b, 2) && $past(rw_or_write_pin, 2)) else $error("bus driven without read");
    a_drive_release: assert property ($rose(cs_b) |-> ##[1:5] data_oe_b_ff)
        else $error("bus kept after select");
    a_quiet_at_release: assert property ($rose(rst_b) |-> data_oe_b_ff &&
        alert_tone_pin_oe_b_ff && tx_code_ff == 4'h0 && !tone_output_enable_ff &&
        !tone_detect_mode_bit_ff) else $error("outputs active at reset");
    a_tx_by_access: assert property ($changed(tx_code_ff) |-> idle_ff < 4'h8)
        else $error("tx code moved without access");
    a_ctrl_a_access: assert property ($changed(tone_detect_mode_bit_ff) |-> idle_ff < 4'h8)
        else $error("mode moved without access");
    a_ctrl_b_access: assert property ($changed({single_tone_ff, tone_group_ff}) |->
        idle_ff < 4'h8) else $error("tone shape moved without access");
    a_rx_power_access: assert property ($changed(rx_power_down_ff) |-> idle_ff < 4'h8)
        else $error("rx power moved without access");
    c_read: cover property ($fell(data_oe_b_ff));
    c_alert: cover property ($fell(alert_tone_pin_oe_b_ff));
    c_single: cover property ($rose(single_tone_ff));
endmodule
bind dtap_host_port dtap_host_port_asserts chk (.*);
`default_nettype wire

// ---- dtap_host_model.sv ----
`default_nettype none
module dtap_host_model (
    input  wire logic       core_clk,
    input  wire logic [3:0] data_out_ff,
    input  wire logic       data_oe_b_ff,
    output var  logic       cs_b,
    output var  logic       strobe_or_read_pin,
    output var  logic       rw_or_write_pin,
    output var  logic       register_select_line,
    output var  logic [3:0] data_in
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        cs_b = 1'b1;
        strobe_or_read_pin = 1'b1;
        rw_or_write_pin = 1'b1;
        register_select_line = 1'b0;
        data_in = 4'h0;
    end
    // One access per select; released data lines show the inverse, never a stale copy.
    task automatic access(input logic split, input logic wr, input logic sel,
                          input logic [3:0] wd, output logic [3:0] rd, output logic oe);
        @(posedge core_clk);
        strobe_or_read_pin <= split;
        rw_or_write_pin <= split | !wr;
        register_select_line <= sel;
        data_in <= wr ? wd : ~data_in;
        repeat (3) @(posedge core_clk);
        cs_b <= 1'b0;
        repeat (4) @(posedge core_clk);
        if (!split) begin
            strobe_or_read_pin <= 1'b1;
        end else if (wr) begin
            rw_or_write_pin <= 1'b0;
        end else begin
            strobe_or_read_pin <= 1'b0;
        end
        repeat (8) @(posedge core_clk);
        rd = data_out_ff;
        oe = data_oe_b_ff;
        strobe_or_read_pin <= split;
        if (split) begin
            rw_or_write_pin <= 1'b1;
        end
        repeat (4) @(posedge core_clk);
        cs_b <= 1'b1;
        data_in <= ~data_in;
        repeat (3) @(posedge core_clk);
    endtask
endmodule
`default_nettype wire

// ---- dtap_host_port_bench.sv ----
`default_nettype none
module dtap_host_port_bench;
    timeunit 1ns;
    timeprecision 1ps;
    logic       core_clk = 1'b0;
    logic       rst_b = 1'b0;
    logic       tone_present = 1'b0;
    logic [3:0] tone_code = 4'h0;
    logic       cp_square = 1'b1;
    wire  [3:0] data_in, data_out_ff, tx_code_ff;
    wire        cs_b, strobe_or_read_pin, rw_or_write_pin, register_select_line;
    wire        data_oe_b_ff, alert_tone_pin_out_ff, alert_tone_pin_oe_b_ff;
    wire        tone_output_enable_ff, single_tone_ff, tone_group_ff;
    wire        rx_power_down_ff, tone_detect_mode_bit_ff;
    // Pull-up on the open-drain alert line: a floating pin reads high.
    wire        alert = alert_tone_pin_oe_b_ff | alert_tone_pin_out_ff;
    int         failures = 0;
    int         compares = 0;
    logic [3:0] rd;
    logic       oe;
    always #2.5 core_clk = ~core_clk;
    dtap_host_model host (.*);
    dtap_host_port #(.BURST_CYC(20), .GTP_CYC(4), .GTA_CYC(4)) dut (.*);
    task automatic chk(input string what, input logic [3:0] seen, input logic [3:0] exp);
        compares++;
        if (seen !== exp) begin
            failures++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic give_verdict;
        if (failures == 0 && compares > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    task automatic acc(input logic split, input logic wr, input logic sel, input logic [3:0] d);
        host.access(split, wr, sel, d, rd, oe);
    endtask
    task automatic tone(input logic [3:0] code, input int on, input int gap);
        @(posedge core_clk);
        tone_present <= 1'b1;
        tone_code <= code;
        repeat (on) @(posedge core_clk);
        tone_present <= 1'b0;
        repeat (gap) @(posedge core_clk);
    endtask
    initial begin
        repeat (5000) @(posedge core_clk);
        failures++;
        give_verdict();
    end
    initial begin
        repeat (3) @(posedge core_clk);
        rst_b <= 1'b1;
        acc(1, 0, 1, 4'h0);
        chk("status", rd, 4'h2);
        chk("drive", 4'(oe), 4'h0);
        acc(0, 1, 1, 4'h4);
        tone(4'h5, 2, 10);
        chk("alert", 4'(alert), 4'h1);
        acc(0, 0, 0, 4'h0);
        chk("rx", rd, 4'h0);
        tone(4'h5, 10, 2);
        tone(4'h9, 10, 10);
        chk("alert", 4'(alert), 4'h0);
        acc(1, 0, 1, 4'h0);
        chk("status", rd, 4'h7);
        chk("alert", 4'(alert), 4'h1);
        acc(0, 0, 0, 4'h0);
        chk("rx", rd, 4'h5);
        tone(4'h9, 10, 10);
        acc(1, 0, 0, 4'h0);
        chk("rx", rd, 4'h9);
        acc(0, 0, 1, 4'h0);
        chk("status", rd, 4'h3);
        acc(1, 1, 1, 4'h8);
        acc(1, 1, 1, 4'hc);
        chk("single", 4'(single_tone_ff), 4'h1);
        chk("group", 4'(tone_group_ff), 4'h1);
        acc(1, 1, 1, 4'h5);
        chk("single", 4'(single_tone_ff), 4'h1);
        chk("cp", 4'(tone_detect_mode_bit_ff), 4'h0);
        acc(1, 1, 0, 4'ha);
        chk("tx", tx_code_ff, 4'ha);
        chk("alert", 4'(alert), 4'h1);
        repeat (60) @(posedge core_clk);
        chk("alert", 4'(alert), 4'h0);
        acc(1, 0, 1, 4'h0);
        chk("status", rd, 4'h3);
        acc(1, 1, 1, 4'h8);
        chk("tx", tx_code_ff, 4'h0);
        acc(1, 1, 1, 4'h1);
        chk("single", 4'(single_tone_ff), 4'h0);
        acc(1, 1, 1, 4'h1);
        chk("tone on", 4'(tone_output_enable_ff), 4'h1);
        acc(0, 1, 0, 4'h3);
        chk("tx", tx_code_ff, 4'h3);
        chk("alert", 4'(alert), 4'h1);
        acc(0, 1, 1, 4'h6);
        chk("cp", 4'(tone_detect_mode_bit_ff), 4'h1);
        chk("rx off", 4'(rx_power_down_ff), 4'h0);
        cp_square <= 1'b0;
        repeat (6) @(posedge core_clk);
        chk("alert", 4'(alert), 4'h0);
        cp_square <= 1'b1;
        repeat (6) @(posedge core_clk);
        chk("alert", 4'(alert), 4'h1);
        tone(4'h7, 10, 10);
        acc(1, 0, 0, 4'h0);
        chk("rx", rd, 4'h9);
        acc(1, 1, 1, 4'he);
        acc(1, 1, 1, 4'h2);
        chk("rx off", 4'(rx_power_down_ff), 4'h1);
        acc(1, 1, 1, 4'h3);
        acc(1, 1, 0, 4'h7);
        chk("tone on", 4'(tone_output_enable_ff), 4'h1);
        repeat (30) @(posedge core_clk);
        acc(1, 0, 1, 4'h0);
        chk("status", rd, 4'h0);
        repeat (30) @(posedge core_clk);
        acc(1, 0, 1, 4'h0);
        chk("status", rd, 4'h3);
        give_verdict();
    end
endmodule
`default_nettype wire
